// >>> core/dds_pkg.sv
// constants shared by the sine synthesizer core
// Function
// RULE1: clear low zeroes word, accumulator, sine stage
// RULE2: output held while clear; restarts after release
// RULE3: select high: load on synchronized strobe rise
// RULE4: select low: load word every clock edge
// RULE5: format select: 1 offset binary, 0 two's
// RULE6: host spaces strobe rises three clocks apart
// RULE7: strobe rise synchronized before loading word
// RULE8: one 10-bit sample per clock, bit 9 MSB
// RULE9: outputs and state change only on clock; clear_n low zeroes datapath and sine stage at once, without an edge
// RULE10: clock mode: new frequency after five cycles
// RULE11: strobe mode: new frequency after seven cycles
// RULE12: peak and trough codes per format
// RULE13: strobe ignored while select is low
// RULE14: host drives 23-bit word, bit 0 LSB
// RULE15: after clear, zeros until word loaded
// RULE16: 24-bit accumulator adds zero-extended word
// RULE17: upper 14 phase bits give 10-bit amplitude
// RULE18: host holds word two clocks around strobe
// RULE19: pipeline split free; latencies exact
package dds_pkg;
	localparam int TW_W     = 23;
	localparam int ACC_W    = 24;
	localparam int PHASE_W  = 14;
	localparam int SAMPLE_W = 10;
	localparam int MAG_W    = SAMPLE_W - 1;
	localparam int HALF_W   = PHASE_W - 1;
	localparam int PROD_W   = HALF_W + PHASE_W;
	localparam int SCALE_W  = PROD_W + MAG_W;
	localparam int MAG_LSB  = 2 * HALF_W - 2;

	localparam logic [PHASE_W-1:0] HALF_SPAN = 14'h2000;
	localparam logic [MAG_W-1:0]   MAG_FULL  = 9'h1FF;

	localparam int AXI_AW = 5;
	localparam logic [AXI_AW-1:0] REG_TW     = 5'h00;
	localparam logic [AXI_AW-1:0] REG_PHASE  = 5'h04;
	localparam logic [AXI_AW-1:0] REG_SAMPLE = 5'h08;
	localparam logic [AXI_AW-1:0] REG_HOPS   = 5'h0C;
	localparam logic [AXI_AW-1:0] REG_CTRL   = 5'h10;

	localparam int CTRL_CNT_EN  = 0;
	localparam int CTRL_CNT_CLR = 1;
	localparam int CTRL_SEL     = 2;
	localparam int CTRL_FMT     = 3;
	localparam int CTRL_LOADED  = 4;
	localparam logic CTRL_CNT_EN_RST = 1'b1;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> core/dds_top.sv
// sine synthesizer core: tuning word, accumulator, output format, register slave
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
module dds_top (
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	input  wire logic                        clear_n,
	input  wire logic                        load_clock_select,
	input  wire logic                        output_format_select,
	input  wire logic                        hop_strobe,
	input  wire logic [dds_pkg::TW_W-1:0]     tuning_word_in,
	output logic      [dds_pkg::SAMPLE_W-1:0] sine_sample_out,
	input  wire logic [dds_pkg::AXI_AW-1:0]   s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic      [1:0]                  s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [dds_pkg::AXI_AW-1:0]   s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic      [31:0]                 s_axi_rdata,
	output logic      [1:0]                  s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready
);
	localparam int TW_W = dds_pkg::TW_W;
	localparam int ACC_W = dds_pkg::ACC_W;
	localparam int PH_W = dds_pkg::PHASE_W;
	localparam int S_W = dds_pkg::SAMPLE_W;
	localparam int AW = dds_pkg::AXI_AW;

	function automatic logic is_mapped(input logic [AW-1:0] a);
		is_mapped = (a == dds_pkg::REG_TW) || (a == dds_pkg::REG_PHASE) ||
			(a == dds_pkg::REG_SAMPLE) || (a == dds_pkg::REG_HOPS) ||
			(a == dds_pkg::REG_CTRL);
	endfunction

	logic load_sel_s;
	logic fmt_s;
	logic hop_s;

	// mode pins and strobe cross into the clock domain first
	sync_stage #(
		.W(3)
	) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       ({load_clock_select, output_format_select, hop_strobe}),
		.q       ({load_sel_s, fmt_s, hop_s})
	); // RULE7

	phase_link_if link ();

	sine_stage u_sine (
		.aclk    (aclk),
		.aresetn (aresetn),
		.clear_n (clear_n),
		.link    (link)
	);

	// datapath state, cleared asynchronously
	logic [TW_W-1:0]  tw_ff;
	logic [ACC_W-1:0] acc_ff;
	logic [PH_W-1:0]  phase_d1_ff;
	logic             loaded_ff;
	logic [S_W-1:0]   sample_ff;
	logic [TW_W-1:0]  nxt_tw;
	logic [ACC_W-1:0] nxt_acc;
	logic [PH_W-1:0]  nxt_phase;
	logic             nxt_loaded;
	logic [S_W-1:0]   nxt_sample;

	// strobe edge and word capture
	logic             hop_prev_ff;
	logic [TW_W-1:0]  tw_d1_ff;
	logic [TW_W-1:0]  tw_d2_ff;
	logic             hop_rise;
	logic             hop_load;

	assign hop_rise = hop_s & ~hop_prev_ff;
	assign hop_load = load_sel_s & hop_rise; // RULE13

	always_comb begin
		nxt_tw     = tw_ff;
		nxt_loaded = loaded_ff;
		if (!load_sel_s) begin // RULE4
			nxt_tw     = tuning_word_in;
			nxt_loaded = 1'b1;
		end else if (hop_rise) begin // RULE3
			nxt_tw     = tw_d2_ff;
			nxt_loaded = 1'b1;
		end
		nxt_acc   = acc_ff + {1'b0, tw_ff}; // RULE16
		nxt_phase = acc_ff[ACC_W-1 -: PH_W]; // RULE17
		nxt_sample = '0; // RULE15
		if (loaded_ff) begin // RULE5 RULE12
			nxt_sample = {link.neg ^ fmt_s, link.mag ^ {(S_W-1){link.neg}}};
		end
	end

	always_ff @(posedge aclk or negedge clear_n) begin
		if (!clear_n) begin // RULE1 RULE2
			tw_ff       <= '0;
			acc_ff      <= '0;
			phase_d1_ff <= '0;
			loaded_ff   <= 1'b0;
			sample_ff   <= '0;
		end else if (!aresetn) begin
			tw_ff       <= '0;
			acc_ff      <= '0;
			phase_d1_ff <= '0;
			loaded_ff   <= 1'b0;
			sample_ff   <= '0;
		end else begin // RULE9 RULE19
			tw_ff       <= nxt_tw;
			acc_ff      <= nxt_acc;
			phase_d1_ff <= nxt_phase;
			loaded_ff   <= nxt_loaded;
			sample_ff   <= nxt_sample; // RULE10 RULE11
		end
	end

	assign link.phase = phase_d1_ff;
	assign sine_sample_out = sample_ff; // RULE8

	// control and slave state
	logic [31:0]    hop_count_ff;
	logic           cnt_en_ff;
	logic           aw_hold_ff;
	logic [AW-1:0]  awaddr_ff;
	logic           w_hold_ff;
	logic [31:0]    wdata_ff;
	logic [3:0]     wstrb_ff;
	logic           bvalid_ff;
	logic [1:0]     bresp_ff;
	logic           rvalid_ff;
	logic [31:0]    rdata_ff;
	logic [1:0]     rresp_ff;
	logic [31:0]    nxt_hop_count;
	logic           nxt_cnt_en;
	logic           nxt_aw_hold;
	logic [AW-1:0]  nxt_awaddr;
	logic           nxt_w_hold;
	logic [31:0]    nxt_wdata;
	logic [3:0]     nxt_wstrb;
	logic           nxt_bvalid;
	logic [1:0]     nxt_bresp;
	logic           nxt_rvalid;
	logic [31:0]    nxt_rdata;
	logic [1:0]     nxt_rresp;
	logic           do_write;
	logic           ctrl_wr;

	assign s_axi_awready = ~aw_hold_ff & ~bvalid_ff;
	assign s_axi_wready  = ~w_hold_ff & ~bvalid_ff;
	assign s_axi_arready = ~rvalid_ff;
	assign do_write = aw_hold_ff & w_hold_ff & ~bvalid_ff;
	assign ctrl_wr  = do_write & (awaddr_ff == dds_pkg::REG_CTRL) & wstrb_ff[0];

	always_comb begin
		nxt_aw_hold = aw_hold_ff;
		nxt_awaddr  = awaddr_ff;
		nxt_w_hold  = w_hold_ff;
		nxt_wdata   = wdata_ff;
		nxt_wstrb   = wstrb_ff;
		nxt_bvalid  = bvalid_ff;
		nxt_bresp   = bresp_ff;
		nxt_cnt_en  = cnt_en_ff;
		nxt_hop_count = hop_count_ff;
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_aw_hold = 1'b1;
			nxt_awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_w_hold = 1'b1;
			nxt_wdata  = s_axi_wdata;
			nxt_wstrb  = s_axi_wstrb;
		end
		if (do_write) begin
			nxt_aw_hold = 1'b0;
			nxt_w_hold  = 1'b0;
			nxt_bvalid  = 1'b1;
			nxt_bresp   = is_mapped(awaddr_ff) ? dds_pkg::RESP_OKAY : dds_pkg::RESP_SLVERR;
		end else if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
		if (ctrl_wr) begin
			nxt_cnt_en = wdata_ff[dds_pkg::CTRL_CNT_EN];
			if (wdata_ff[dds_pkg::CTRL_CNT_CLR]) begin
				nxt_hop_count = '0;
			end
		end
		// a hop in the clearing cycle still counts
		if (hop_load && cnt_en_ff) begin
			nxt_hop_count = nxt_hop_count + 32'h00000001;
		end
	end

	always_comb begin
		nxt_rvalid = rvalid_ff;
		nxt_rdata  = rdata_ff;
		nxt_rresp  = rresp_ff;
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_rvalid = 1'b1;
			nxt_rresp  = is_mapped(s_axi_araddr) ? dds_pkg::RESP_OKAY : dds_pkg::RESP_SLVERR;
			case (s_axi_araddr)
				dds_pkg::REG_TW: begin
					nxt_rdata = {{(32-TW_W){1'b0}}, tw_ff};
				end
				dds_pkg::REG_PHASE: begin
					nxt_rdata = {{(32-ACC_W){1'b0}}, acc_ff};
				end
				dds_pkg::REG_SAMPLE: begin
					nxt_rdata = {{(32-S_W){1'b0}}, sample_ff};
				end
				dds_pkg::REG_HOPS: begin
					nxt_rdata = hop_count_ff;
				end
				dds_pkg::REG_CTRL: begin
					nxt_rdata = 32'h00000000;
					nxt_rdata[dds_pkg::CTRL_CNT_EN] = cnt_en_ff;
					nxt_rdata[dds_pkg::CTRL_SEL]    = load_sel_s;
					nxt_rdata[dds_pkg::CTRL_FMT]    = fmt_s;
					nxt_rdata[dds_pkg::CTRL_LOADED] = loaded_ff;
				end
				default: begin
					nxt_rdata = 32'h00000000;
				end
			endcase
		end else if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hop_prev_ff  <= 1'b0;
			tw_d1_ff     <= '0;
			tw_d2_ff     <= '0;
			hop_count_ff <= '0;
			cnt_en_ff    <= dds_pkg::CTRL_CNT_EN_RST;
			aw_hold_ff   <= 1'b0;
			awaddr_ff    <= '0;
			w_hold_ff    <= 1'b0;
			wdata_ff     <= '0;
			wstrb_ff     <= '0;
			bvalid_ff    <= 1'b0;
			bresp_ff     <= dds_pkg::RESP_OKAY;
			rvalid_ff    <= 1'b0;
			rdata_ff     <= '0;
			rresp_ff     <= dds_pkg::RESP_OKAY;
		end else begin
			hop_prev_ff  <= hop_s;
			// word rides two flops beside the strobe, aligned to its sampling edge
			tw_d1_ff     <= tuning_word_in;
			tw_d2_ff     <= tw_d1_ff;
			hop_count_ff <= nxt_hop_count;
			cnt_en_ff    <= nxt_cnt_en;
			aw_hold_ff   <= nxt_aw_hold;
			awaddr_ff    <= nxt_awaddr;
			w_hold_ff    <= nxt_w_hold;
			wdata_ff     <= nxt_wdata;
			wstrb_ff     <= nxt_wstrb;
			bvalid_ff    <= nxt_bvalid;
			bresp_ff     <= nxt_bresp;
			rvalid_ff    <= nxt_rvalid;
			rdata_ff     <= nxt_rdata;
			rresp_ff     <= nxt_rresp;
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp  = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata  = rdata_ff;
	assign s_axi_rresp  = rresp_ff;

	property p_clear_zero;
		@(posedge aclk) disable iff (!aresetn)
		!clear_n |-> (tw_ff == '0) && (acc_ff == '0) && (sample_ff == '0);
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("clear left state nonzero"); // RULE1

	property p_sys_load;
		@(posedge aclk) disable iff (!aresetn || !clear_n)
		!load_sel_s |=> tw_ff == $past(tuning_word_in);
	endproperty
	a_sys_load: assert property (p_sys_load) else $error("word not loaded on clock"); // RULE4

	property p_hop_load;
		@(posedge aclk) disable iff (!aresetn || !clear_n)
		load_sel_s && hop_rise |=> tw_ff == $past(tw_d2_ff);
	endproperty
	a_hop_load: assert property (p_hop_load) else $error("strobe load missed"); // RULE3

	property p_hop_hold;
		@(posedge aclk) disable iff (!aresetn || !clear_n)
		load_sel_s && !hop_rise |=> $stable(tw_ff);
	endproperty
	a_hop_hold: assert property (p_hop_hold) else $error("word changed without strobe"); // RULE3

	property p_acc_step;
		@(posedge aclk) disable iff (!aresetn || !clear_n)
		1'b1 ##1 clear_n |-> acc_ff == $past(acc_ff) + {1'b0, $past(tw_ff)};
	endproperty
	a_acc_step: assert property (p_acc_step) else $error("accumulator step wrong"); // RULE16

	property p_phase_tap;
		@(posedge aclk) disable iff (!aresetn || !clear_n)
		1'b1 ##1 clear_n |-> phase_d1_ff == $past(acc_ff[ACC_W-1 -: PH_W]);
	endproperty
	a_phase_tap: assert property (p_phase_tap) else $error("phase tap wrong"); // RULE17

	property p_out_latency;
		@(posedge aclk) disable iff (!aresetn || !clear_n)
		(1'b1 ##4 $past(loaded_ff)) |->
			sine_sample_out[S_W-1] == ($past(acc_ff[ACC_W-1], 4) ^ $past(fmt_s));
	endproperty
	a_out_latency: assert property (p_out_latency) else $error("sample sign late"); // RULE10

	property p_unloaded_zero;
		@(posedge aclk) disable iff (!aresetn)
		!loaded_ff ##1 1'b1 |-> sine_sample_out == '0;
	endproperty
	a_unloaded_zero: assert property (p_unloaded_zero) else $error("output before load"); // RULE15

	property p_hop_ignored;
		@(posedge aclk) disable iff (!aresetn)
		!load_sel_s && !ctrl_wr |=> $stable(hop_count_ff);
	endproperty
	a_hop_ignored: assert property (p_hop_ignored) else $error("strobe seen in clock mode"); // RULE13

	property p_bresp_both;
		@(posedge aclk) disable iff (!aresetn)
		$rose(bvalid_ff) |-> $past(aw_hold_ff) && $past(w_hold_ff);
	endproperty
	a_bresp_both: assert property (p_bresp_both) else $error("response before both halves");
endmodule

// >>> core/phase_link_if.sv
// phase in, amplitude out between the core and the sine stage
interface phase_link_if;
	logic [dds_pkg::PHASE_W-1:0] phase;
	logic [dds_pkg::MAG_W-1:0]   mag;
	logic                        neg;

	modport core (output phase, input mag, input neg);
	modport sine (input phase, output mag, output neg);
endinterface

// >>> core/sine_stage.sv
// half-wave parabolic sine amplitude, two pipeline stages
module sine_stage (
	input  wire logic  aclk,
	input  wire logic  aresetn,
	input  wire logic  clear_n,
	phase_link_if.sine link
);
	logic                         half_ff;
	logic [dds_pkg::HALF_W-1:0]   pos_ff;
	logic                         neg_ff;
	logic [dds_pkg::MAG_W-1:0]    mag_ff;
	logic                         nxt_half;
	logic [dds_pkg::HALF_W-1:0]   nxt_pos;
	logic [dds_pkg::MAG_W-1:0]    nxt_mag;
	logic [dds_pkg::PHASE_W-1:0]  rest;
	logic [dds_pkg::PROD_W-1:0]   prod;
	logic [dds_pkg::SCALE_W-1:0]  scaled;

	always_comb begin
		nxt_half = link.phase[dds_pkg::PHASE_W-1];
		nxt_pos  = link.phase[dds_pkg::HALF_W-1:0];
		rest     = dds_pkg::HALF_SPAN - {1'b0, pos_ff};
		// u*(1-u) peaks at a quarter of span squared, scaled to full magnitude
		prod     = pos_ff * rest;
		scaled   = prod * dds_pkg::MAG_FULL;
		nxt_mag  = scaled[dds_pkg::MAG_LSB +: dds_pkg::MAG_W]; // RULE17
	end

	always_ff @(posedge aclk or negedge clear_n) begin
		if (!clear_n) begin // RULE1
			half_ff <= 1'b0;
			pos_ff  <= '0;
			neg_ff  <= 1'b0;
			mag_ff  <= '0;
		end else if (!aresetn) begin
			half_ff <= 1'b0;
			pos_ff  <= '0;
			neg_ff  <= 1'b0;
			mag_ff  <= '0;
		end else begin
			half_ff <= nxt_half;
			pos_ff  <= nxt_pos;
			neg_ff  <= half_ff;
			mag_ff  <= nxt_mag;
		end
	end

	assign link.neg = neg_ff;
	assign link.mag = mag_ff;
endmodule

// >>> core/sync_stage.sv
// two-flop synchronizer for pin levels
module sync_stage #(
	parameter int W = 1
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_ff <= '0;
			q_ff    <= '0;
		end else begin
			meta_ff <= d;
			q_ff    <= meta_ff;
		end
	end

	assign q = q_ff;
endmodule

// >>> sim/hop_host.sv
// host model: presents the frequency word and pulses the asynchronous hop strobe
module hop_host (
	input  wire logic                     fire,
	input  wire logic [3:0]               pulses,
	input  wire logic [dds_pkg::TW_W-1:0] word,
	output logic                          hop_strobe,
	output logic      [dds_pkg::TW_W-1:0] tuning_word_in
);
	timeunit 1ns;
	timeprecision 100ps;

	localparam time HALF_PERIOD = 80ns;

	assign tuning_word_in = word;

	// strobe rests low between bursts; rises sit off the system clock edge
	initial begin
		hop_strobe = 1'b0;
		forever begin
			@(posedge fire);
			#7;
			repeat (pulses) begin
				hop_strobe = 1'b1;
				#HALF_PERIOD;
				hop_strobe = 1'b0;
				#HALF_PERIOD;
			end
		end
	end
endmodule

// >>> sim/phase_accumulator_sine_synth_bench.sv
// self-checking bench for the sine synthesizer core
module phase_accumulator_sine_synth_bench;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int LIMIT = 4000;

	logic                            aclk, aresetn, clear_n, sel, fmt, fire, hop;
	logic [dds_pkg::AXI_AW-1:0]      awaddr, araddr;
	logic [31:0]                     wdata, rdata;
	logic [1:0]                      bresp, rresp;
	logic                            awvalid, awready, wvalid, wready, bvalid, bready;
	logic                            arvalid, arready, rvalid, rready;
	logic [3:0]                      pulses;
	logic [dds_pkg::TW_W-1:0]        word, tw_pin;
	logic [dds_pkg::SAMPLE_W-1:0]    sample;
	int                              fail_count, n_tests, cyc;

	hop_host u_hop_host (.fire(fire), .pulses(pulses), .word(word), .hop_strobe(hop),
		.tuning_word_in(tw_pin));

	dds_top u_dds_top (.aclk(aclk), .aresetn(aresetn), .clear_n(clear_n),
		.load_clock_select(sel), .output_format_select(fmt), .hop_strobe(hop),
		.tuning_word_in(tw_pin), .sine_sample_out(sample),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		n_tests++;
		if (seen !== want) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, want, seen);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// bready and rready stay high throughout, so the answer is taken when it shows
	task automatic wr(input logic [dds_pkg::AXI_AW-1:0] a, input logic [31:0] d,
			output logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
	endtask

	task automatic rd(input logic [dds_pkg::AXI_AW-1:0] a, output logic [31:0] d,
			output logic [1:0] r, output int t);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				t = cyc;
			end
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
	endtask

	task automatic rdchk(input logic [dds_pkg::AXI_AW-1:0] a, input logic [31:0] want);
		logic [31:0] d;
		logic [1:0]  r;
		int          t;
		rd(a, d, r, t);
		check("register data", d, want);
		check("register response", {30'h0, r}, {30'h0, dds_pkg::RESP_OKAY});
	endtask

	task automatic t_regs();
		logic [31:0] d;
		logic [1:0]  r;
		int          t;
		rdchk(dds_pkg::REG_CTRL, 32'h0000_0011);
		rd(5'h14, d, r, t);
		check("unmapped read response", {30'h0, r}, {30'h0, dds_pkg::RESP_SLVERR});
		check("unmapped read data", d, 32'h0);
		wr(5'h14, 32'hFFFF_FFFF, r);
		check("unmapped write response", {30'h0, r}, {30'h0, dds_pkg::RESP_SLVERR});
	endtask

	// quarter-rate word: phase walks 0, peak, 0, trough
	task automatic t_clock_latency();
		word <= 23'h40_0000;
		step(6);
		check("sample before new word", {22'h0, sample}, 32'h0);
		step(1);
		check("first new sample", {22'h0, sample}, 32'h1FF);
	endtask

	task automatic t_formats();
		int                           peaks, troughs;
		logic [dds_pkg::SAMPLE_W-1:0] hi, lo;
		for (int f = 0; f < 2; f++) begin
			fmt <= f[0];
			hi = f[0] ? 10'h3FF : 10'h1FF;
			lo = f[0] ? 10'h000 : 10'h200;
			peaks = 0;
			troughs = 0;
			step(10);
			repeat (8) begin
				@(posedge aclk);
				peaks += (sample === hi);
				troughs += (sample === lo);
			end
			check("peak count", peaks, 2);
			check("trough count", troughs, 2);
		end
		rdchk(dds_pkg::REG_CTRL, 32'h0000_0019);
	endtask

	task automatic t_accumulate();
		logic [31:0] p1, p2, diff, adv;
		logic [1:0]  r;
		int          t1, t2;
		word <= 23'h7F_FFFF;
		step(3);
		rdchk(dds_pkg::REG_TW, 32'h007F_FFFF);
		rd(dds_pkg::REG_PHASE, p1, r, t1);
		rd(dds_pkg::REG_PHASE, p2, r, t2);
		diff = (p2 - p1) & 32'h00FF_FFFF;
		adv = (32'h007F_FFFF * (t2 - t1)) & 32'h00FF_FFFF;
		check("accumulator advance", diff, adv);
	endtask

	task automatic t_strobe();
		logic [1:0] r;
		wr(dds_pkg::REG_CTRL, 32'h0000_0003, r);
		check("control write response", {30'h0, r}, {30'h0, dds_pkg::RESP_OKAY});
		sel <= 1'b1;
		fmt <= 1'b0;
		word <= 23'h40_0000;
		step(4);
		// clear acts at once; it is driven on the edge like every other input except the hop strobe
		clear_n <= 1'b0;
		#1;
		check("sample in clear", {22'h0, sample}, 32'h0);
		@(posedge aclk);
		rdchk(dds_pkg::REG_PHASE, 32'h0);
		rdchk(dds_pkg::REG_TW, 32'h0);
		rdchk(dds_pkg::REG_SAMPLE, 32'h0);
		clear_n <= 1'b1;
		repeat (20) begin
			@(posedge aclk);
			check("sample before hop", {22'h0, sample}, 32'h0);
		end
		pulses <= 4'h1;
		fire <= 1'b1;
		@(posedge hop);
		@(posedge aclk);
		fire <= 1'b0;
		step(7);
		check("sample before hop load", {22'h0, sample}, 32'h0);
		step(1);
		check("sample after hop load", {22'h0, sample}, 32'h1FF);
		pulses <= 4'h2;
		fire <= 1'b1;
		step(24);
		rdchk(dds_pkg::REG_HOPS, 32'h3);
		rdchk(dds_pkg::REG_CTRL, 32'h0000_0015);
		sel <= 1'b0;
		fire <= 1'b0;
		step(3);
		fire <= 1'b1;
		step(24);
		rdchk(dds_pkg::REG_HOPS, 32'h3);
	endtask

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			fail_count++;
			conclude();
		end
	end

	initial begin
		aresetn = 1'b0;
		clear_n = 1'b1;
		sel = 1'b0;
		fmt = 1'b0;
		fire = 1'b0;
		pulses = 4'h0;
		word = '0;
		awaddr = '0;
		araddr = '0;
		wdata = 32'h0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		arvalid = 1'b0;
		bready = 1'b1;
		rready = 1'b1;
		step(20);
		aresetn <= 1'b1;
		step(3);
		t_regs();
		t_clock_latency();
		t_formats();
		t_accumulate();
		t_strobe();
		conclude();
	end
endmodule
